// file: hdl/uts_pkg.sv
// Constants and types shared by the transfer status queue.
`default_nettype none

package uts_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned TCY_NS        = 20;
  localparam int unsigned REARM_MAX_TCY = 5;
  localparam int unsigned REARM_RAW     = (REARM_MAX_TCY * TCY_NS) / CLK_PERIOD_NS;
  localparam int unsigned REARM_MAX_CYC = (REARM_RAW < 1) ? 1 : REARM_RAW;

  // ****************************************************************
  // Queue shape
  // ****************************************************************
  localparam int unsigned QUEUE_DEPTH = 4;
  localparam int unsigned ENTRY_W     = 8;
  localparam int unsigned PTR_W       = 2;
  localparam int unsigned CNT_W       = 3;
  localparam logic [CNT_W-1:0] QUEUE_FULL_CNT = 3'h4;

  // ****************************************************************
  // Register map and fields
  // ****************************************************************
  localparam logic [11:0] ADDR_STATUS_WINDOW = 12'hF64;
  localparam logic [11:0] ADDR_FLAG_CTRL     = 12'hF68;
  localparam int unsigned EPNUM_LSB = 3;
  localparam int unsigned EPNUM_MSB = 6;
  localparam int unsigned DIR_BIT   = 2;
  localparam int unsigned ODD_BIT   = 1;
  localparam int unsigned FLAG_BIT  = 0;
  localparam int unsigned OVF_BIT   = 1;
  localparam int unsigned FULL_BIT  = 2;
  localparam int unsigned NAKS_BIT  = 3;
  localparam int unsigned COUNT_LSB = 4;
  localparam logic        FLAG_RST  = 1'h0;
  localparam logic [31:0] DATA_RST  = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_EMPTY   = 3'b001,
    ST_POSTED  = 3'b010,
    ST_ADVANCE = 3'b100
  } uts_flag_state_t;

endpackage : uts_pkg

`default_nettype wire

// file: hdl/uts_queue_if.sv
// Push and pop port between the control logic and the status queue.
`default_nettype none

interface uts_queue_if;
  import uts_pkg::*;
  logic               push;
  logic [ENTRY_W-1:0] push_data;
  logic               pop;
  logic [ENTRY_W-1:0] head;
  logic [CNT_W-1:0]   count;
  logic               full;
  logic               dropped;
  modport queue (input push, push_data, pop, output head, count, full, dropped);
  modport ctrl  (output push, push_data, pop, input head, count, full, dropped);
endinterface : uts_queue_if

`default_nettype wire

// file: hdl/uts_sticky_bit.sv
// Sticky status bit where a set in the same cycle beats a clear.
`default_nettype none

module uts_sticky_bit
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic set,
  input  wire logic clr,
  output var  logic q
);
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      q <= 1'b0;
    else if (set)
      q <= 1'b1;
    else if (clr)
      q <= 1'b0;
  end
endmodule : uts_sticky_bit

`default_nettype wire

// file: hdl/uts_status_queue.sv
// Four-entry status queue held in flip-flops.
`default_nettype none

module uts_status_queue
  import uts_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  uts_queue_if.queue q
);
  logic [ENTRY_W-1:0] mem_q [QUEUE_DEPTH];
  logic [PTR_W-1:0]   rd_ptr_q;
  logic [PTR_W-1:0]   wr_ptr_q;
  logic [CNT_W-1:0]   count_q;
  logic               full_q;
  logic               do_pop;
  logic               do_push;

  // A push while full is taken only if a pop frees a slot in the same cycle.
  assign do_pop    = q.pop && (count_q != 3'h0);
  assign do_push   = q.push && (!full_q || do_pop);
  assign q.dropped = q.push && !do_push;
  assign q.head    = mem_q[rd_ptr_q];
  assign q.count   = count_q;
  assign q.full    = full_q;

  always_ff @(posedge clk)
  begin
    if (do_push)
      mem_q[wr_ptr_q] <= q.push_data;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_ptr_q <= 2'h0;
      wr_ptr_q <= 2'h0;
      count_q  <= 3'h0;
      full_q   <= 1'b0;
    end
    else
    begin
      if (do_push)
        wr_ptr_q <= wr_ptr_q + 2'h1;
      if (do_pop)
        rd_ptr_q <= rd_ptr_q + 2'h1;
      if (do_push && !do_pop)
      begin
        count_q <= count_q + 3'h1;
        full_q  <= (count_q + 3'h1) == QUEUE_FULL_CNT;
      end
      else if (do_pop && !do_push)
      begin
        count_q <= count_q - 3'h1;
        full_q  <= 1'b0;
      end
    end
  end
endmodule : uts_status_queue

`default_nettype wire

// file: hdl/uts_top.sv
// Transfer status reporting: status queue, completion flag and register slave.
`default_nettype none

module uts_top
  import uts_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [11:0] WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output var  logic [31:0] WB_DAT_O,
  output var  logic        WB_ACK_O,
  input  wire logic        XFER_DONE,
  input  wire logic [3:0]  XFER_EPNUM,
  input  wire logic        XFER_DIR,
  input  wire logic        XFER_ODD,
  input  wire logic        TOKEN_REQ,
  output var  logic        TOKEN_NAK,
  output var  logic        TRANSFER_DONE_FLAG,
  output var  logic        QUEUE_FULL
);

  localparam int REARM_BOUND = REARM_MAX_CYC;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  uts_queue_if     qif ();
  uts_flag_state_t state_q;
  uts_flag_state_t state_d;
  logic            flag_q;
  logic            bus_req;
  logic            bus_wr;
  logic            hit_window;
  logic            hit_ctrl;
  logic            clear_req;
  logic            ovf_clr;
  logic            naks_clr;
  logic            ovf_q;
  logic            naks_q;
  logic            nak_d;
  logic [31:0]     rd_data_d;
  logic [7:0]      window_byte;

  // ****************************************************************
  // Status queue
  // ****************************************************************
  uts_status_queue u_queue
  (
    .clk (CORE_CLK),
    .rst (RST),
    .q   (qif.queue)
  );

  // Bits 7 and 0 are stored as zero so the head byte is the window as is.
  assign qif.push      = XFER_DONE;
  assign qif.push_data = {1'b0, XFER_EPNUM, XFER_DIR, XFER_ODD, 1'b0};
  assign qif.pop       = clear_req && (state_q == ST_POSTED);

  // ****************************************************************
  // Wishbone slave
  // ****************************************************************
  // One wait state: ack rises in the cycle after the request appears and
  // drops one cycle later, so back to back requests see a gap.
  assign bus_req    = WB_CYC_I && WB_STB_I;
  assign bus_wr     = bus_req && WB_WE_I && WB_ACK_O;
  assign hit_window = (WB_ADR_I[11:2] == ADDR_STATUS_WINDOW[11:2]);
  assign hit_ctrl   = (WB_ADR_I[11:2] == ADDR_FLAG_CTRL[11:2]);
  assign clear_req  = bus_wr && hit_ctrl && WB_SEL_I[0] && WB_DAT_I[FLAG_BIT];
  assign ovf_clr    = bus_wr && hit_ctrl && WB_SEL_I[0] && WB_DAT_I[OVF_BIT];
  assign naks_clr   = bus_wr && hit_ctrl && WB_SEL_I[0] && WB_DAT_I[NAKS_BIT];

  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
      WB_ACK_O <= 1'b0;
    else
      WB_ACK_O <= bus_req && !WB_ACK_O;
  end

  // The window is a plain read: reading it never pops, only the flag clear does.
  assign window_byte = qif.head & 8'h7E;

  always_comb
  begin
    rd_data_d = DATA_RST;
    if (hit_window)
    begin
      rd_data_d[7:0] = window_byte;
    end
    else if (hit_ctrl)
    begin
      rd_data_d[FLAG_BIT]  = flag_q;
      rd_data_d[OVF_BIT]   = ovf_q;
      rd_data_d[FULL_BIT]  = qif.full;
      rd_data_d[NAKS_BIT]  = naks_q;
      rd_data_d[COUNT_LSB +: CNT_W] = qif.count;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
      WB_DAT_O <= DATA_RST;
    else if (bus_req && !WB_ACK_O && !WB_WE_I)
      WB_DAT_O <= rd_data_d;
  end

  // ****************************************************************
  // Completion flag
  // ****************************************************************
  // The flag is not cleared by writing zero; a one written to its bit pops
  // the head. A clear while the flag is low has no effect.
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_EMPTY:
      begin
        if (qif.count != 3'h0)
          state_d = ST_POSTED;
      end
      ST_POSTED:
      begin
        if (clear_req)
          state_d = ST_ADVANCE;
      end
      ST_ADVANCE:
      begin
        if (qif.count != 3'h0)
          state_d = ST_POSTED;
        else
          state_d = ST_EMPTY;
      end
      default:
      begin
        state_d = ST_EMPTY;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
      state_q <= ST_EMPTY;
    else
      state_q <= state_d;
  end

  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
      flag_q <= FLAG_RST;
    else
      flag_q <= (state_d == ST_POSTED);
  end

  assign TRANSFER_DONE_FLAG = flag_q;
  assign QUEUE_FULL         = qif.full;

  // ****************************************************************
  // Host request refusal and sticky status
  // ****************************************************************
  // The refusal looks at the registered full state, so a slot freed in the
  // same cycle as a request still refuses it; the host simply retries.
  assign nak_d = TOKEN_REQ && qif.full;

  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
      TOKEN_NAK <= 1'b0;
    else
      TOKEN_NAK <= nak_d;
  end

  uts_sticky_bit u_ovf
  (
    .clk (CORE_CLK),
    .rst (RST),
    .set (qif.dropped),
    .clr (ovf_clr),
    .q   (ovf_q)
  );

  uts_sticky_bit u_naks
  (
    .clk (CORE_CLK),
    .rst (RST),
    .set (nak_d),
    .clr (naks_clr),
    .q   (naks_q)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_pop_with_more;
    qif.pop && (qif.count > 3'h1);
  endsequence

  sequence s_pop_last;
    qif.pop && (qif.count == 3'h1) && !qif.push;
  endsequence

  a_rearm_within_bound: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    s_pop_with_more |-> ##[1:REARM_BOUND] TRANSFER_DONE_FLAG)
    else $error("Flag not set again after pop with entries left.");

  a_empty_flag_low: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    s_pop_last ##1 !qif.push |-> !TRANSFER_DONE_FLAG ##1 !TRANSFER_DONE_FLAG)
    else $error("Flag set with an empty queue.");

  a_flag_has_entry: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    TRANSFER_DONE_FLAG |-> (qif.count != 3'h0))
    else $error("Flag high while the queue is empty.");

  a_nak_when_full: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    TOKEN_REQ && QUEUE_FULL |=> TOKEN_NAK)
    else $error("Request while full was not refused.");

  a_no_nak_free: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    !(TOKEN_REQ && QUEUE_FULL) |=> !TOKEN_NAK)
    else $error("Refusal without a full queue.");

  a_push_queues: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    XFER_DONE && !QUEUE_FULL && !qif.pop |=> qif.count == $past(qif.count) + 3'h1)
    else $error("Completed transfer not queued.");

  a_pop_advances: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    qif.pop && !XFER_DONE |=> qif.count == $past(qif.count) - 3'h1)
    else $error("Clear did not advance the queue.");

  a_head_fields: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    XFER_DONE && (qif.count == 3'h0)
    |=> qif.head[EPNUM_MSB:EPNUM_LSB] == $past(XFER_EPNUM)
        && qif.head[DIR_BIT] == $past(XFER_DIR)
        && qif.head[ODD_BIT] == $past(XFER_ODD))
    else $error("Head entry does not match the posted transfer.");

  a_window_zero_bits: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    WB_ACK_O && !WB_WE_I && hit_window |-> WB_DAT_O[7] == 1'b0 && WB_DAT_O[0] == 1'b0)
    else $error("Unimplemented window bits read as one.");

  a_ack_single: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    WB_ACK_O |=> !WB_ACK_O)
    else $error("Acknowledge held longer than one cycle.");

  // ****************************************************************
  // Further checks
  // ****************************************************************
  sequence s_first_post;
    XFER_DONE && (qif.count == 3'h0) && (state_q == ST_EMPTY);
  endsequence

  sequence s_window_read;
    WB_ACK_O && !WB_WE_I && hit_window;
  endsequence

  a_flag_after_post: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    s_first_post |=> ##1 TRANSFER_DONE_FLAG)
    else $error("Flag not raised after the first posted transfer.");

  a_window_shows_head: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    s_window_read |-> WB_DAT_O[7:0] == $past(window_byte) && WB_DAT_O[31:8] == 24'h0)
    else $error("Window read does not show the queue head.");

  a_full_at_four: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    QUEUE_FULL == (qif.count == QUEUE_FULL_CNT))
    else $error("Full indication disagrees with the entry count.");

  a_count_in_range: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    qif.count <= QUEUE_FULL_CNT)
    else $error("Entry count above the queue depth.");

  a_head_kept: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    !qif.pop && (qif.count != 3'h0) |=> $stable(qif.head))
    else $error("Queued head entry was overwritten.");

  a_full_keeps_count: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    XFER_DONE && QUEUE_FULL && !qif.pop |=> qif.count == $past(qif.count))
    else $error("Push into a full queue changed the count.");

  a_pop_drops_flag: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    qif.pop |=> !TRANSFER_DONE_FLAG)
    else $error("Flag still high after the head was popped.");

  a_clear_when_low: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    clear_req && !TRANSFER_DONE_FLAG |-> !qif.pop)
    else $error("Clear while the flag was low popped an entry.");

  a_drop_sets_ovf: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    qif.dropped |=> ovf_q)
    else $error("Dropped entry did not set the overflow bit.");

  a_nak_sets_seen: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    nak_d |=> naks_q)
    else $error("Refusal did not set the refusal seen bit.");

  a_ack_follows_req: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    bus_req && !WB_ACK_O |=> WB_ACK_O)
    else $error("Request not acknowledged after one wait cycle.");

  a_read_data_held: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    !(bus_req && !WB_ACK_O && !WB_WE_I) |=> $stable(WB_DAT_O))
    else $error("Read data changed without a new read request.");

endmodule : uts_top

`default_nettype wire

// file: test/uts_engine_model.sv
// Behavioural engine and host side that posts transfers and endpoint requests.
`default_nettype none

module uts_engine_model
(
  input  wire logic       clk,
  output var  logic       xfer_done,
  output var  logic [3:0] xfer_epnum,
  output var  logic       xfer_dir,
  output var  logic       xfer_odd,
  output var  logic       token_req
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    {xfer_done, xfer_epnum, xfer_dir, xfer_odd, token_req} = 8'h00;
  end

  // One finished buffer; calls may follow back to back with the pulse held.
  task automatic finish(input logic [3:0] e, input logic d, input logic o);
    xfer_done <= 1'b1;
    xfer_epnum <= e;
    xfer_dir  <= d;
    xfer_odd  <= o;
    @(posedge clk);
  endtask : finish

  // Released fields show the inverse, so a stale value cannot pass for a fresh one.
  task automatic idle();
    xfer_done <= 1'b0;
    xfer_epnum <= ~xfer_epnum;
    xfer_dir  <= ~xfer_dir;
    xfer_odd  <= ~xfer_odd;
    @(posedge clk);
  endtask : idle

  task automatic token();
    token_req <= 1'b1;
    @(posedge clk);
    token_req <= 1'b0;
  endtask : token
endmodule : uts_engine_model

`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the transfer status queue.
`default_nettype none

module testbench;
  import uts_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we  = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] dat_o;
  logic        ack, nak, flag, full, done, dir, odd, treq;
  logic [3:0]  epnum;
  logic [31:0] exp_q[$];
  logic [7:0]  ent[5];
  logic [3:0]  ep;
  int          miscompares = 0;
  int          check_count = 0;
  int unsigned seed;

  uts_top i_dut (.CORE_CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .XFER_DONE(done), .XFER_EPNUM(epnum), .XFER_DIR(dir), .XFER_ODD(odd), .TOKEN_REQ(treq),
    .TOKEN_NAK(nak), .TRANSFER_DONE_FLAG(flag), .QUEUE_FULL(full));

  uts_engine_model i_eng (.clk(clk), .xfer_done(done), .xfer_epnum(epnum), .xfer_dir(dir),
    .xfer_odd(odd), .token_req(treq));

  initial
  begin
    forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
                    input logic [31:0] e);
    int n;
    n = 0;
    if (!w) exp_q.push_back(e);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    @(posedge clk);
    while (ack !== 1'b1)
    begin
      @(posedge clk);
      n++;
    end
    chk(n, 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk);
  endtask : wb

  // Pop the head and watch the flag fall, then come back when entries remain.
  task automatic pop_next(input logic more);
    int n;
    n = 0;
    wb(1'b1, ADDR_FLAG_CTRL, 32'h1, 32'h0);
    chk({31'h0, flag}, 32'h0);
    while (flag !== 1'b1 && more && n < REARM_MAX_CYC)
    begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, flag}, {31'h0, more});
  endtask : pop_next

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize

  // Read data is judged at the acknowledge edge against the oldest note.
  always @(posedge clk)
  begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) chk(dat_o, exp_q.pop_front());
  end

  initial
  begin
    repeat (4000) @(posedge clk);
    $display("watchdog expired");
    miscompares++;
    summarize();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    seed = $urandom(32'hDD05);
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({30'h0, flag, full}, 32'h0);
    wb(1'b0, ADDR_FLAG_CTRL, 32'h0, 32'h0);
    wb(1'b1, 12'hF6C, 32'hFF, 32'h0);
    wb(1'b0, 12'hF6C, 32'h0, 32'h0);
    i_eng.finish(4'h3, 1'b1, 1'b0);
    i_eng.idle();
    repeat (2) @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({30'h0, flag, full}, 32'h0);
    wb(1'b0, ADDR_FLAG_CTRL, 32'h0, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 5; i++)
    begin
      ep = (i == 0) ? 4'hF : 4'($urandom);
      ent[i] = {1'b0, ep, i[0], i[1], 1'b0};
      i_eng.finish(ep, i[0], i[1]);
    end
    i_eng.idle();
    chk({30'h0, flag, full}, 32'h3);
    i_eng.token();
    @(posedge clk);
    chk({31'h0, nak}, 32'h1);
    wb(1'b0, ADDR_FLAG_CTRL, 32'h0, 32'h4F);
    $display("test fill done");
    for (int i = 0; i < 4; i++)
    begin
      // Window read only while the flag is up.
      wb(1'b0, ADDR_STATUS_WINDOW, 32'h0, {24'h0, ent[i]});
      pop_next(i < 3);
    end
    repeat (10) @(posedge clk);
    chk({31'h0, flag}, 32'h0);
    i_eng.token();
    @(posedge clk);
    chk({31'h0, nak}, 32'h0);
    wb(1'b1, ADDR_FLAG_CTRL, 32'hA, 32'h0);
    wb(1'b0, ADDR_FLAG_CTRL, 32'h0, 32'h0);
    $display("test drain done");
    summarize();
  end
endmodule : testbench

`default_nettype wire
